// file: hw/crc8_byte.sv
`default_nettype none
module crc8_byte #(
    parameter logic [7:0] POLY = 8'h07
) (
    input  wire logic [7:0] crc_in,
    input  wire logic [7:0] data_in,
    output logic      [7:0] crc_out
);
    // msb-first crc over one byte
    always_comb begin
        logic [7:0] c;
        c = crc_in ^ data_in;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ POLY) : (c << 1);
        end
        crc_out = c;
    end
endmodule : crc8_byte
`default_nettype wire

// file: hw/smbus_port_pkg.sv
`default_nettype none
package smbus_port_pkg;
    localparam int          CLK_HZ       = 10_000_000;
    // bus-off detection time and bit timing of the master
    localparam int          OFF_TIME_MS  = 2000;
    localparam int unsigned OFF_CYC_DEF  = OFF_TIME_MS * (CLK_HZ / 1000);
    localparam int          QTR_NS       = 2500;
    localparam int unsigned QTR_CYC_DEF  = (QTR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [6:0]  SLAVE_ADDR   = 7'h0b;
    localparam logic [7:0]  HOST_ADDR    = 8'h10;
    localparam logic [7:0]  CHARGER_ADDR = 8'h12;
    localparam logic [7:0]  CRC_POLY     = 8'h07;
    localparam logic [7:0]  BLK_LEN      = 8'h02;
    localparam logic [1:0]  ERR_NONE     = 2'h0;
    localparam logic [1:0]  ERR_PEC      = 2'h1;
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_MASTER   = 8'h04;
    localparam logic [7:0]  OFS_STATUS   = 8'h08;
    localparam logic [7:0]  OFS_SLV_TX   = 8'h0c;
    localparam logic [7:0]  OFS_SLV_RX   = 8'h10;
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam int          CTRL_TARGET  = 0;
    localparam int          CTRL_NOSLEEP = 4;
    localparam int          CTRL_HPE     = 5;
    localparam int          CTRL_CPE     = 6;

    typedef struct packed {
        logic [15:0] word;
        logic [7:0]  cmd;
    } smb_word_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
    } avmm_req_t;

    typedef enum logic [2:0] {
        SL_IDLE  = 3'b000,
        SL_RX    = 3'b001,
        SL_ACK   = 3'b011,
        SL_TX    = 3'b010,
        SL_ACKIN = 3'b110,
        SL_WAIT  = 3'b111
    } sl_state_t;

    typedef enum logic [1:0] {
        M_IDLE  = 2'b00,
        M_START = 2'b01,
        M_BIT   = 2'b11,
        M_STOP  = 2'b10
    } m_state_t;
endpackage : smbus_port_pkg
`default_nettype wire

// file: hw/smbus_port_with_pec.sv
// Contract
// - master opens transfer with start condition
// - address 0001011, rw bit, then command
// - rw bit and command pick store/return
// - master closes access with stop condition
// - bytes travel most significant bit first
// - broadcasts go to 0x12 or 0x10
// - slave serves read word, write word, block read
// - as master only write word is issued
// - pins open drain, never driven high
// - last byte sender appends pec byte
// - receiver recomputes pec and compares
// - messages accepted with or without pec
// - pec expected after host data bytes
// - pec match acks, mismatch nacks, error recorded
// - after host ack device sends pec
// - sleep needs low current, bus off, bit4 zero
// - line rising edge or current wakes device
// - pec is crc8 with x8+x2+x+1
// - crc covers every byte, no ack or conditions
// - both lines low 2 s means bus off
// - separate pec enables for host, charger
`default_nettype none
module smbus_port_with_pec #(
    parameter int unsigned OFF_CYC = smbus_port_pkg::OFF_CYC_DEF,
    parameter int unsigned QTR_CYC = smbus_port_pkg::QTR_CYC_DEF
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    input  wire smbus_port_pkg::avmm_req_t avs_req,
    output logic                    [31:0] avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic                      current_below_sleep,
    input  wire logic                      bus_clock_pin_i,
    output logic                           bus_clock_pin_o,
    output logic                           bus_clock_pin_oe,
    input  wire logic                      bus_data_pin_i,
    output logic                           bus_data_pin_o,
    output logic                           bus_data_pin_oe,
    output logic                           sleep_mode
);
    import smbus_port_pkg::*;

    logic [1:0] scl_sy, sda_sy;
    logic       scl_d, sda_d;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            scl_sy <= 2'b11;
            sda_sy <= 2'b11;
            scl_d  <= 1'b1;
            sda_d  <= 1'b1;
        end else begin
            scl_sy <= {scl_sy[0], bus_clock_pin_i};
            sda_sy <= {sda_sy[0], bus_data_pin_i};
            scl_d  <= scl_sy[1];
            sda_d  <= sda_sy[1];
        end
    end
    wire scl       = scl_sy[1];
    wire sda       = sda_sy[1];
    wire scl_rise  = scl & ~scl_d;
    wire scl_fall  = ~scl & scl_d;
    wire sda_rise  = sda & ~sda_d;
    wire start_det = scl & scl_d & sda_d & ~sda;
    wire stop_det  = scl & scl_d & ~sda_d & sda;

    // register bus: one wait cycle, then the answer
    logic       ack_reg;
    logic [7:0] ctrl_reg, blk_cmd_reg;
    logic [15:0] tx_word_reg;
    smb_word_t  m_word, rx_tmp, rx_reg;
    logic       rx_valid, go_pend, m_nack, bus_off, sleep_reg;
    logic [1:0] err_code;
    m_state_t   m_st;
    sl_state_t  sl_st;
    wire        acc      = avs_req.read | avs_req.write;
    wire        wr_en    = avs_req.write & ack_reg;
    wire        rd_en    = avs_req.read & ack_reg;
    wire        sel_ctrl = avs_req.address == OFS_CTRL;
    wire        sel_mst  = avs_req.address == OFS_MASTER;
    wire        sel_stat = avs_req.address == OFS_STATUS;
    wire        sel_stx  = avs_req.address == OFS_SLV_TX;
    wire        sel_srx  = avs_req.address == OFS_SLV_RX;
    wire        busy     = (m_st != M_IDLE) | go_pend;
    wire [31:0] rd_mux   = sel_ctrl ? {24'h000000, ctrl_reg} :
                           sel_mst  ? {8'h00, m_word} :
                           sel_stat ? {25'h0000000, rx_valid, err_code, sleep_reg, bus_off, m_nack, busy} :
                           sel_stx  ? {8'h00, blk_cmd_reg, tx_word_reg} :
                           sel_srx  ? {8'h00, rx_reg} : 32'h00000000;
    assign avs_waitrequest = acc & ~ack_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_reg      <= 1'b0;
            avs_readdata <= 32'h00000000;
            ctrl_reg     <= CTRL_RST;
            blk_cmd_reg  <= 8'h00;
            tx_word_reg  <= 16'h0000;
        end else begin
            ack_reg <= acc & ~ack_reg;
            if (acc & ~ack_reg) begin
                avs_readdata <= rd_mux;
            end
            if (wr_en & sel_ctrl) begin
                ctrl_reg <= avs_req.writedata[7:0];
            end
            if (wr_en & sel_stx) begin
                {blk_cmd_reg, tx_word_reg} <= avs_req.writedata[23:0];
            end
        end
    end

    // bus-off watch and sleep control
    logic [31:0] low_cnt;
    wire both_low = ~scl & ~sda;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_cnt   <= 32'h00000000;
            bus_off   <= 1'b0;
            sleep_reg <= 1'b0;
        end else begin
            if (!both_low) begin
                low_cnt <= 32'h00000000;
                bus_off <= 1'b0;
            end else if (low_cnt == OFF_CYC - 1) begin
                bus_off <= 1'b1;
            end else begin
                low_cnt <= low_cnt + 32'h00000001;
            end
            if (scl_rise | sda_rise | ~current_below_sleep) begin
                sleep_reg <= 1'b0;
            end else if (bus_off & current_below_sleep & ~ctrl_reg[CTRL_NOSLEEP]) begin
                sleep_reg <= 1'b1;
            end
        end
    end
    assign sleep_mode = sleep_reg;

    // slave engine
    logic [7:0] sh, crc_s;
    logic [3:0] bitc;
    logic [2:0] idx, tx_i;
    logic       got_cmd, rd_mode, blk, pec_bad, host_ack, sda_s_low;
    wire  [7:0] crc_s_nx;
    wire  [2:0] tx_len   = blk ? 3'd3 : 3'd2;
    wire  [7:0] tx_data  = blk ? ((tx_i == 3'd0) ? BLK_LEN :
                                  (tx_i == 3'd1) ? tx_word_reg[7:0] : tx_word_reg[15:8]) :
                                 ((tx_i == 3'd0) ? tx_word_reg[7:0] : tx_word_reg[15:8]);
    wire  [7:0] tx_byte  = (tx_i == tx_len) ? crc_s : tx_data;
    wire        addr_ok  = sh[7:1] == SLAVE_ADDR;
    wire        pec_ok   = sh == crc_s;
    wire        byte_end = scl_fall & (sl_st == SL_RX) & (bitc == 4'd8);
    wire        tx_load  = scl_fall & (((sl_st == SL_ACK) & rd_mode) |
                           ((sl_st == SL_ACKIN) & host_ack & (tx_i <= tx_len)));
    wire  [7:0] crc_s_in = (sl_st == SL_RX) ? sh : tx_byte;

    crc8_byte #(.POLY(CRC_POLY)) u_crc_s (
        .crc_in  (crc_s),
        .data_in (crc_s_in),
        .crc_out (crc_s_nx)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sl_st <= SL_IDLE;
            sh <= 8'h00;
            crc_s <= 8'h00;
            bitc <= 4'h0;
            idx <= 3'd0;
            tx_i <= 3'd0;
            {got_cmd, rd_mode, blk, pec_bad, host_ack, sda_s_low, rx_valid} <= 7'h00;
            rx_tmp <= '0;
            rx_reg <= '0;
            err_code <= ERR_NONE;
        end else begin
            if (rd_en & sel_srx) begin
                rx_valid <= 1'b0;
            end
            if (start_det) begin
                sl_st <= SL_RX;
                bitc <= 4'h0;
                idx <= 3'd0;
                pec_bad <= 1'b0;
                sda_s_low <= 1'b0;
                if (!got_cmd) begin
                    crc_s <= 8'h00;
                end
            end else if (stop_det) begin
                sl_st <= SL_IDLE;
                sda_s_low <= 1'b0;
                {got_cmd, rd_mode} <= 2'b00;
                if (!rd_mode && idx >= 3'd4 && !pec_bad) begin
                    rx_reg <= rx_tmp;
                    rx_valid <= 1'b1;
                end
            end else if (scl_rise & (sl_st == SL_RX)) begin
                sh <= {sh[6:0], sda};
                bitc <= bitc + 4'h1;
            end else if (scl_rise & (sl_st == SL_ACKIN)) begin
                host_ack <= ~sda;
            end else if (byte_end) begin
                bitc <= 4'h0;
                sl_st <= SL_ACK;
                sda_s_low <= 1'b1;
                if (idx != 3'd5) begin
                    idx <= idx + 3'd1;
                end
                if (idx != 3'd4) begin
                    crc_s <= crc_s_nx;
                end
                case (idx)
                    3'd0: begin
                        if (!addr_ok) begin
                            sl_st <= SL_WAIT;
                            sda_s_low <= 1'b0;
                        end
                        rd_mode <= addr_ok & sh[0] & got_cmd;
                        tx_i <= 3'd0;
                    end
                    3'd1: begin
                        rx_tmp.cmd <= sh;
                        got_cmd <= 1'b1;
                        blk <= sh == blk_cmd_reg;
                    end
                    3'd2: rx_tmp.word[7:0] <= sh;
                    3'd3: rx_tmp.word[15:8] <= sh;
                    3'd4: begin
                        sda_s_low <= pec_ok;
                        pec_bad <= ~pec_ok;
                        err_code <= pec_ok ? ERR_NONE : ERR_PEC;
                    end
                    default: sda_s_low <= 1'b0;
                endcase
            end else if (tx_load) begin
                sl_st <= SL_TX;
                sh <= tx_byte;
                bitc <= 4'h1;
                sda_s_low <= ~tx_byte[7];
                if (tx_i != tx_len) begin
                    crc_s <= crc_s_nx;
                end
            end else if (scl_fall) begin
                case (sl_st)
                    SL_ACK: begin
                        sda_s_low <= 1'b0;
                        sl_st <= SL_RX;
                    end
                    SL_TX: begin
                        if (bitc == 4'd8) begin
                            sda_s_low <= 1'b0;
                            sl_st <= SL_ACKIN;
                            tx_i <= tx_i + 3'd1;
                        end else begin
                            sh <= {sh[6:0], 1'b0};
                            sda_s_low <= ~sh[6];
                            bitc <= bitc + 4'h1;
                        end
                    end
                    SL_ACKIN: sl_st <= SL_WAIT;
                    default: sl_st <= sl_st;
                endcase
            end
        end
    end

    // master engine: write word broadcasts only
    logic [31:0] qcnt;
    logic [1:0]  q;
    logic [3:0]  mbit;
    logic [2:0]  mbyte;
    logic [7:0]  msh, m_crc;
    logic        m_scl_low, m_sda_low, m_pec_en;
    wire  [7:0]  crc_m_nx;
    wire         tick    = qcnt == QTR_CYC - 1;
    wire  [7:0]  m_addr  = ctrl_reg[CTRL_TARGET] ? CHARGER_ADDR : HOST_ADDR;
    wire  [2:0]  m_last  = m_pec_en ? 3'd4 : 3'd3;
    wire  [2:0]  m_nidx  = (m_st == M_START) ? 3'd0 : mbyte + 3'd1;
    wire  [7:0]  m_nb    = (m_nidx == 3'd0) ? m_addr :
                           (m_nidx == 3'd1) ? m_word.cmd :
                           (m_nidx == 3'd2) ? m_word.word[7:0] :
                           (m_nidx == 3'd3) ? m_word.word[15:8] : m_crc;
    wire  [7:0]  crc_m_in = (m_st == M_START) ? 8'h00 : m_crc;
    wire         m_go    = go_pend & tick & (sl_st == SL_IDLE) & scl & sda;

    crc8_byte #(.POLY(CRC_POLY)) u_crc_m (
        .crc_in  (crc_m_in),
        .data_in (m_nb),
        .crc_out (crc_m_nx)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            m_st <= M_IDLE;
            qcnt <= 32'h00000000;
            q <= 2'd0;
            mbit <= 4'h0;
            mbyte <= 3'd0;
            msh <= 8'h00;
            m_crc <= 8'h00;
            {m_scl_low, m_sda_low, m_pec_en, m_nack, go_pend} <= 5'h00;
            m_word <= '0;
        end else begin
            qcnt <= tick ? 32'h00000000 : qcnt + 32'h00000001;
            if (wr_en & sel_mst & ~busy) begin
                m_word <= avs_req.writedata[23:0];
                go_pend <= 1'b1;
            end
            if (tick) begin
                q <= q + 2'd1;
            end
            case (m_st)
                M_IDLE: if (m_go) begin
                    go_pend <= 1'b0;
                    m_nack <= 1'b0;
                    m_pec_en <= ctrl_reg[CTRL_TARGET] ? ctrl_reg[CTRL_CPE] : ctrl_reg[CTRL_HPE];
                    m_st <= M_START;
                    q <= 2'd0;
                end
                M_START: if (tick) begin
                    if (q == 2'd0) begin
                        m_sda_low <= 1'b1;
                    end else begin
                        m_scl_low <= 1'b1;
                        m_st <= M_BIT;
                        q <= 2'd0;
                        mbit <= 4'h0;
                        mbyte <= 3'd0;
                        msh <= m_nb;
                        m_crc <= crc_m_nx;
                    end
                end
                M_BIT: if (tick) begin
                    case (q)
                        2'd0: m_sda_low <= (mbit != 4'd8) & ~msh[7];
                        2'd1: m_scl_low <= 1'b0;
                        2'd2: if (mbit == 4'd8) m_nack <= m_nack | sda;
                        default: begin
                            m_scl_low <= 1'b1;
                            if (mbit != 4'd8) begin
                                msh <= {msh[6:0], 1'b0};
                                mbit <= mbit + 4'h1;
                            end else if (mbyte == m_last) begin
                                m_st <= M_STOP;
                            end else begin
                                mbyte <= m_nidx;
                                mbit <= 4'h0;
                                msh <= m_nb;
                                if (m_nidx != 3'd4) begin
                                    m_crc <= crc_m_nx;
                                end
                            end
                        end
                    endcase
                end
                M_STOP: if (tick) begin
                    case (q)
                        2'd0: m_sda_low <= 1'b1;
                        2'd1: m_scl_low <= 1'b0;
                        default: begin
                            m_sda_low <= 1'b0;
                            m_st <= M_IDLE;
                        end
                    endcase
                end
                default: m_st <= M_IDLE;
            endcase
        end
    end

    // open-drain pins: only ever pull low
    assign bus_clock_pin_o  = 1'b0;
    assign bus_data_pin_o   = 1'b0;
    assign bus_clock_pin_oe = m_scl_low;
    assign bus_data_pin_oe  = m_sda_low | sda_s_low;

    AST_OPEN_DRAIN: assert property (@(posedge ref_clk) disable iff (rst)
        !bus_clock_pin_o && !bus_data_pin_o) else $error("pin driven high");
    AST_SLEEP_COND: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(sleep_reg) |-> $past(bus_off) && !$past(ctrl_reg[CTRL_NOSLEEP])) else $error("bad sleep entry");
    AST_WAKE: assert property (@(posedge ref_clk) disable iff (rst)
        (sleep_reg && (scl_rise || sda_rise)) |=> !sleep_reg) else $error("no wake on edge");
    AST_BUS_OFF: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(bus_off) |-> $past(low_cnt) == OFF_CYC - 1) else $error("bus off timing");
    AST_PEC_CHECK: assert property (@(posedge ref_clk) disable iff (rst)
        (byte_end && idx == 3'd4 && !start_det && !stop_det) |=> (sda_s_low == pec_bad) == 1'b0
        && err_code == (pec_bad ? ERR_PEC : ERR_NONE)) else $error("pec answer wrong");
    AST_M_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
        (m_st == M_START && tick && q == 2'd1) |=> msh == HOST_ADDR || msh == CHARGER_ADDR) else $error("bad target");
    AST_M_START: assert property (@(posedge ref_clk) disable iff (rst)
        (m_st == M_START && $rose(m_sda_low)) |-> !m_scl_low) else $error("start with clock low");
    AST_M_STOP: assert property (@(posedge ref_clk) disable iff (rst)
        ($fell(m_sda_low) && $past(m_st) == M_STOP) |-> !m_scl_low) else $error("stop with clock low");
    AST_M_PEC: assert property (@(posedge ref_clk) disable iff (rst)
        (m_st == M_BIT && mbyte == 3'd4 && mbit == 4'd0 && q == 2'd0 && tick) |-> m_pec_en && msh == m_crc)
        else $error("pec byte wrong");
endmodule : smbus_port_with_pec
`default_nettype wire

// file: sim/smbus_host_model.sv
`default_nettype none
module smbus_host_model (
    input  wire logic ref_clk,
    input  wire logic scl,
    input  wire logic sda,
    output var logic  scl_oe,
    output var logic  sda_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got [$];
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // a quarter of the 800 ns link bit
    task q;
        repeat (2) @(posedge ref_clk);
    endtask : q
    task pull(input logic c, input logic d);
        scl_oe <= c;
        sda_oe <= d;
    endtask : pull
    // works from idle or from a low clock, so it also gives a repeated start
    task start;
        sda_oe <= 1'b0;
        q;
        scl_oe <= 1'b0;
        q;
        sda_oe <= 1'b1;
        q;
        scl_oe <= 1'b1;
        q;
    endtask : start
    task stop;
        sda_oe <= 1'b1;
        q;
        scl_oe <= 1'b0;
        q;
        sda_oe <= 1'b0;
        q;
    endtask : stop
    // data only changes while the clock is held low
    task bit_io(input logic b, output logic s);
        sda_oe <= !b;
        q;
        scl_oe <= 1'b0;
        q;
        s = sda;
        q;
        scl_oe <= 1'b1;
        q;
    endtask : bit_io
    task tx(input logic [7:0] d, output logic nak);
        for (int i = 7; i >= 0; i--) bit_io(d[i], nak);
        bit_io(1'b1, nak);
    endtask : tx
    task rx(output logic [7:0] d, input logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!ack, s);
    endtask : rx
    // passive receiver of the device's broadcasts, acking every byte
    task listen(input int n);
        logic [7:0] d;
        got.delete();
        @(negedge sda iff scl);
        repeat (n) begin
            repeat (8) begin
                @(posedge scl);
                d = {d[6:0], sda};
            end
            @(negedge scl);
            @(posedge ref_clk);
            sda_oe <= 1'b1;
            @(negedge scl);
            @(posedge ref_clk);
            sda_oe <= 1'b0;
            got.push_back(d);
        end
    endtask : listen
endmodule : smbus_host_model
`default_nettype wire

// file: sim/test_smbus_port_with_pec.sv
`default_nettype none
module test_smbus_port_with_pec;
    timeunit 1ns;
    timeprecision 1ns;
    import smbus_port_pkg::*;
    logic        ref_clk;
    logic        rst;
    avmm_req_t   req;
    logic [31:0] rdata;
    logic        waitreq;
    logic        cur_low;
    logic        scl_oe;
    logic        sda_oe;
    logic        sleep_mode;
    logic        scl;
    logic        sda;
    logic [31:0] v;
    logic        nak;
    int          cycles;
    int          n_errors;
    int          total_checks;
    logic        h_scl_oe;
    logic        h_sda_oe;
    smbus_host_model host (.ref_clk(ref_clk), .scl(scl), .sda(sda), .scl_oe(h_scl_oe), .sda_oe(h_sda_oe));
    assign scl = !(scl_oe | h_scl_oe);
    assign sda = !(sda_oe | h_sda_oe);
    smbus_port_with_pec #(.OFF_CYC(200), .QTR_CYC(4)) DUT (
        .ref_clk(ref_clk), .rst(rst), .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(waitreq),
        .current_below_sleep(cur_low), .bus_clock_pin_i(scl), .bus_clock_pin_o(), .bus_clock_pin_oe(scl_oe),
        .bus_data_pin_i(sda), .bus_data_pin_o(), .bus_data_pin_oe(sda_oe), .sleep_mode(sleep_mode));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            end_of_test;
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task av(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        req <= '{read: !wr, write: wr, address: a, writedata: d};
        // request held until the rising edge that sees waitrequest low
        do @(posedge ref_clk); while (waitreq !== 1'b0);
        q = rdata;
        req <= '0;
    endtask : av
    function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
        return x;
    endfunction : crc
    // mode 0 sends no check byte, 1 a good one, 2 a corrupted one
    task wword(input logic [7:0] a, input logic [7:0] cmd, input logic [15:0] w, input int mode);
        logic [7:0] c;
        c = crc(crc(crc(crc(8'h00, a), cmd), w[7:0]), w[15:8]);
        host.start;
        host.tx(a, nak);
        host.tx(cmd, nak);
        host.tx(w[7:0], nak);
        host.tx(w[15:8], nak);
        if (mode != 0) host.tx(mode == 1 ? c : ~c, nak);
        host.stop;
    endtask : wword
    task rword(input logic [7:0] cmd, input logic blk);
        logic [7:0] e [$];
        logic [7:0] c;
        logic [7:0] d;
        e = {8'he9, 8'h03};
        if (blk) e.push_front(8'h02);
        c = crc(crc(crc(8'h00, 8'h16), cmd), 8'h17);
        host.start;
        host.tx(8'h16, nak);
        host.tx(cmd, nak);
        host.start;
        host.tx(8'h17, nak);
        foreach (e[i]) begin
            host.rx(d, 1'b1);
            check({24'h0, d}, {24'h0, e[i]});
            c = crc(c, e[i]);
        end
        host.rx(d, 1'b0);
        check({24'h0, d}, {24'h0, c});
        host.stop;
    endtask : rword
    task bcast(input logic [7:0] ctrl, input int n, input logic [7:0] adr);
        logic [7:0] e [$];
        av(1'b1, OFS_CTRL, {24'h0, ctrl}, v);
        fork
            host.listen(n);
            av(1'b1, OFS_MASTER, 32'h00abcd16, v);
        join
        e = {adr, 8'h16, 8'hcd, 8'hab};
        e.push_back(crc(crc(crc(crc(8'h00, adr), 8'h16), 8'hcd), 8'hab));
        for (int i = 0; i < n; i++) check({24'h0, host.got[i]}, {24'h0, e[i]});
        do av(1'b0, OFS_STATUS, 32'h0, v); while (v[0] !== 1'b0);
        check({30'h0, v[1:0]}, 32'h0);
    endtask : bcast
    initial begin
        req = '0;
        cur_low = 1'b0;
        rst = 1'b1;
        cycles = 0;
        n_errors = 0;
        total_checks = 0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        av(1'b0, OFS_CTRL, 32'h0, v);
        check(v, 32'h0);
        av(1'b0, 8'h14, 32'h0, v);
        check(v, 32'h0);
        wword(8'h16, 8'h21, 16'h1234, 1);
        check({31'h0, nak}, 32'h0);
        av(1'b0, OFS_STATUS, 32'h0, v);
        check({29'h0, v[6:4]}, 32'h4);
        av(1'b0, OFS_SLV_RX, 32'h0, v);
        check(v, 32'h00123421);
        wword(8'h16, 8'h22, 16'hbeef, 0);
        av(1'b0, OFS_SLV_RX, 32'h0, v);
        check(v, 32'h00beef22);
        wword(8'h16, 8'h23, 16'h5a5a, 2);
        check({31'h0, nak}, 32'h1);
        av(1'b0, OFS_STATUS, 32'h0, v);
        check({30'h0, v[5:4]}, 32'h1);
        wword(8'h18, 8'h24, 16'h0001, 0);
        check({31'h0, nak}, 32'h1);
        av(1'b0, OFS_SLV_RX, 32'h0, v);
        check(v, 32'h00beef22);
        av(1'b1, OFS_SLV_TX, 32'h007703e9, v);
        rword(8'h0f, 1'b0);
        rword(8'h77, 1'b1);
        bcast(8'h20, 5, 8'h10);
        bcast(8'h01, 4, 8'h12);
        bcast(8'h41, 5, 8'h12);
        for (int k = 0; k < 3; k++) begin
            av(1'b1, OFS_CTRL, k == 0 ? 32'h10 : 32'h0, v);
            host.pull(1'b1, 1'b1);
            cur_low <= 1'b1;
            repeat (260) @(posedge ref_clk);
            check({31'h0, sleep_mode}, {31'h0, k != 0});
            av(1'b0, OFS_STATUS, 32'h0, v);
            check({30'h0, v[3:2]}, k == 0 ? 32'h1 : 32'h3);
            if (k == 1) host.pull(1'b1, 1'b0);
            else cur_low <= 1'b0;
            repeat (10) @(posedge ref_clk);
            check({31'h0, sleep_mode}, 32'h0);
            host.pull(1'b0, 1'b0);
            cur_low <= 1'b0;
            repeat (10) @(posedge ref_clk);
        end
        end_of_test;
    end
endmodule : test_smbus_port_with_pec
`default_nettype wire
